// ### clc_cmd.sv
`timescale 1ns/1ps
module clc_cmd (
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	input  wire logic                       i_cfg_enter,
	input  wire logic                       i_rx_valid,
	input  wire logic [7:0]                 i_rx_data,
	output logic                            o_rx_ready,
	input  wire logic                       i_filt_we,
	input  wire logic [clc_pkg::FILT_AW-1:0] i_filt_idx,
	input  wire logic                       i_filt_used,
	input  wire clc_pkg::clc_filt_s         i_filt,
	input  wire logic                       i_tx_ready,
	output clc_pkg::clc_byte_s              o_tx,
	output logic [7:0]                      o_rate_idx,
	output logic                            o_echo_en,
	output logic                            o_cfg_mode
);
	typedef enum {ST_OP, ST_RATE, ST_ECHO, ST_GRATE, ST_GFILT} clc_state_e;

	// ==========================================
	// state
	clc_state_e                 state;
	clc_state_e                 next_state;
	logic [7:0]                 rate;
	logic [7:0]                 next_rate;
	logic                       echo;
	logic                       next_echo;
	logic                       cfg;
	logic                       next_cfg;
	clc_pkg::clc_filt_s         filt_mem [clc_pkg::FILT_DEPTH];
	logic [clc_pkg::FILT_DEPTH-1:0] used;
	logic [clc_pkg::FILT_DEPTH-1:0] next_used;
	logic [clc_pkg::FILT_AW-1:0] rd_idx;
	logic                       rep_busy;
	logic                       rep_start;
	clc_pkg::clc_byte_s         rep_byte;

	function automatic logic rate_ok(input logic [7:0] v);
		rate_ok = (v >= clc_pkg::RATE_MIN) && (v <= clc_pkg::RATE_MAX);
	endfunction

	assign o_rate_idx = rate;
	assign o_echo_en  = echo;
	assign o_cfg_mode = cfg;
	// bytes are held off while a reply is still going out
	assign o_rx_ready = (state == ST_OP) || (state == ST_RATE) || (state == ST_ECHO);
	assign rep_start  = (state == ST_GFILT) && !rep_busy;

	// ==========================================
	// decoder
	always_comb begin
		next_state = state;
		next_rate  = rate;
		next_echo  = echo;
		next_cfg   = cfg;
		o_tx       = rep_byte;
		case (state)
			ST_OP: begin
				if (i_rx_valid && cfg) begin
					case (i_rx_data)
						clc_pkg::OP_SET_RATE: next_state = ST_RATE;
						clc_pkg::OP_SET_ECHO: next_state = ST_ECHO;
						clc_pkg::OP_GET_RATE: next_state = ST_GRATE;
						clc_pkg::OP_GET_FILT: next_state = ST_GFILT;
						clc_pkg::OP_EXIT_CFG: next_cfg = 1'b0;
						default: next_state = ST_OP;
					endcase
				end
				if (i_cfg_enter) begin
					next_cfg = 1'b1;
				end
			end
			ST_RATE: begin
				if (i_rx_valid) begin
					if (rate_ok(i_rx_data)) begin
						next_rate = i_rx_data;
					end
					next_state = ST_OP;
				end
			end
			ST_ECHO: begin
				if (i_rx_valid) begin
					if (i_rx_data == clc_pkg::ECHO_OFF) begin
						next_echo = 1'b0;
					end else if (i_rx_data == clc_pkg::ECHO_ON) begin
						next_echo = 1'b1;
					end
					next_state = ST_OP;
				end
			end
			ST_GRATE: begin
				o_tx.valid = 1'b1;
				o_tx.data  = rate;
				o_tx.last  = 1'b1;
				if (i_tx_ready) begin
					next_state = ST_OP;
				end
			end
			ST_GFILT: begin
				// one cycle after start the serialiser is busy; leave when it finishes
				if (rep_byte.valid && rep_byte.last && i_tx_ready) begin
					next_state = ST_OP;
				end
			end
			default: next_state = ST_OP;
		endcase
	end

	// settings registers; reset drops config mode so nothing changes before the pin is given
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state <= ST_OP;
			rate  <= clc_pkg::RATE_RST;
			echo  <= clc_pkg::ECHO_RST;
			cfg   <= 1'b0;
		end else begin
			state <= next_state;
			rate  <= next_rate;
			echo  <= next_echo;
			cfg   <= next_cfg;
		end
	end

	// ==========================================
	// filter table, written by the add/remove logic elsewhere
	// a removed slot drops its used bit and its words are overwritten with i_filt; unused words are never sent
	always_comb begin
		next_used = used;
		if (i_filt_we) begin
			next_used[i_filt_idx] = i_filt_used;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			used <= '0;
		end else begin
			used <= next_used;
		end
	end

	// contents need no reset: the used bits gate them
	always_ff @(posedge i_clk) begin
		if (i_filt_we) begin
			filt_mem[i_filt_idx] <= i_filt;
		end
	end

	clc_reply u_reply (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_start (rep_start),
		.i_used  (used),
		.i_entry ({filt_mem[rd_idx].mask, filt_mem[rd_idx].id}),
		.i_ready (i_tx_ready),
		.o_idx   (rd_idx),
		.o_busy  (rep_busy),
		.o_byte  (rep_byte)
	);

	// ==========================================
	// checks
	sequence s_rate_cmd;
		state == ST_OP && cfg && i_rx_valid && i_rx_data == clc_pkg::OP_SET_RATE;
	endsequence

	sequence s_filt_cmd;
		state == ST_OP && cfg && i_rx_valid && i_rx_data == clc_pkg::OP_GET_FILT;
	endsequence

	sequence s_filt_last;
		state == ST_GFILT && o_tx.valid && o_tx.last && i_tx_ready;
	endsequence

	AST_RATE_SET: assert property (@(posedge i_clk) disable iff (i_rst)
		s_rate_cmd ##1 (i_rx_valid && rate_ok(i_rx_data)) |=> rate == $past(i_rx_data))
		else $error("rate index not taken");

	AST_RATE_BAD: assert property (@(posedge i_clk) disable iff (i_rst)
		state == ST_RATE && i_rx_valid && !rate_ok(i_rx_data) |=> $stable(rate))
		else $error("bad rate index changed setting");

	AST_ECHO_ON: assert property (@(posedge i_clk) disable iff (i_rst)
		state == ST_ECHO && i_rx_valid && i_rx_data == clc_pkg::ECHO_ON |=> echo)
		else $error("echo not enabled");

	AST_ECHO_OFF: assert property (@(posedge i_clk) disable iff (i_rst)
		state == ST_ECHO && i_rx_valid && i_rx_data == clc_pkg::ECHO_OFF |=> !echo)
		else $error("echo not disabled");

	AST_ECHO_BAD: assert property (@(posedge i_clk) disable iff (i_rst)
		state == ST_ECHO && i_rx_valid && i_rx_data > clc_pkg::ECHO_ON |=> $stable(echo))
		else $error("bad echo state changed setting");

	AST_GET_RATE: assert property (@(posedge i_clk) disable iff (i_rst)
		state == ST_OP && cfg && i_rx_valid && i_rx_data == clc_pkg::OP_GET_RATE
		|=> o_tx.valid && o_tx.last && o_tx.data == rate)
		else $error("rate reply wrong");

	AST_GET_FILT: assert property (@(posedge i_clk) disable iff (i_rst)
		s_filt_cmd |=> ##[1:2] (rep_busy || o_tx.valid))
		else $error("filter reply not started");

	AST_FILT_END: assert property (@(posedge i_clk) disable iff (i_rst)
		s_filt_last |=> state == ST_OP && !rep_busy && o_rx_ready)
		else $error("filter reply did not finish");

	AST_REPLY_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
		o_tx.valid && !i_tx_ready && !i_filt_we
		|=> o_tx.valid && $stable(o_tx.data) && $stable(o_tx.last))
		else $error("reply byte not held while stalled");

	AST_GRATE_END: assert property (@(posedge i_clk) disable iff (i_rst)
		state == ST_GRATE && i_tx_ready |=> state == ST_OP && !o_tx.valid)
		else $error("rate reply sent more than once");

	AST_NO_CFG: assert property (@(posedge i_clk) disable iff (i_rst)
		state == ST_OP && !cfg && i_rx_valid |=> state == ST_OP && $stable(rate) && $stable(echo))
		else $error("command taken outside config mode");

	AST_EXIT: assert property (@(posedge i_clk) disable iff (i_rst)
		state == ST_OP && cfg && i_rx_valid && i_rx_data == clc_pkg::OP_EXIT_CFG && !i_cfg_enter |=> !cfg)
		else $error("exit opcode ignored");

	AST_CFG_ENTER: assert property (@(posedge i_clk) disable iff (i_rst)
		state == ST_OP && i_cfg_enter |=> cfg)
		else $error("config mode not entered");
endmodule

// ### clc_pkg.sv
package clc_pkg;

	// ==========================================
	// opcodes
	localparam logic [7:0] OP_SET_RATE   = 8'h05;
	localparam logic [7:0] OP_SET_ECHO   = 8'h06;
	localparam logic [7:0] OP_GET_RATE   = 8'h0b;
	localparam logic [7:0] OP_GET_FILT   = 8'h09;
	localparam logic [7:0] OP_EXIT_CFG   = 8'hc1;

	// ==========================================
	// bit-rate index range, echo state codes and reset values
	localparam logic [7:0] RATE_MIN      = 8'h01;
	localparam logic [7:0] RATE_MAX      = 8'h08;
	localparam logic [7:0] RATE_RST      = 8'h05;
	localparam logic [7:0] ECHO_OFF      = 8'h00;
	localparam logic [7:0] ECHO_ON       = 8'h01;
	localparam logic       ECHO_RST      = 1'b0;

	// ==========================================
	// filter list
	localparam int         FILT_DEPTH    = 8;
	localparam int         FILT_AW       = 3;

	typedef struct packed {
		logic [31:0] id;
		logic [31:0] mask;
	} clc_filt_s;

	// reply byte stream toward the host
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
	} clc_byte_s;

endpackage

// ### clc_reply.sv
`timescale 1ns/1ps
// ==========================================
// serialiser: streams the filter list as id then mask, lsb first
module clc_reply (
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	input  wire logic                       i_start,
	input  wire logic [clc_pkg::FILT_DEPTH-1:0] i_used,
	input  wire logic [63:0]                i_entry,
	input  wire logic                       i_ready,
	output logic [clc_pkg::FILT_AW-1:0]     o_idx,
	output logic                            o_busy,
	output clc_pkg::clc_byte_s              o_byte
);
	logic [clc_pkg::FILT_AW:0] idx;
	logic [2:0]                bsel;
	logic                      busy;
	logic [clc_pkg::FILT_AW:0] next_idx;
	logic [2:0]                next_bsel;
	logic                      next_busy;
	logic                      sel_used;

	assign o_idx    = idx[clc_pkg::FILT_AW-1:0];
	assign o_busy   = busy;
	assign sel_used = (idx < 4'(clc_pkg::FILT_DEPTH)) && i_used[o_idx];

	// walk entries; unused slots are skipped one per cycle
	always_comb begin
		next_idx  = idx;
		next_bsel = bsel;
		next_busy = busy;
		o_byte    = '0;
		if (!busy) begin
			if (i_start) begin
				next_busy = 1'b1;
				next_idx  = '0;
				next_bsel = '0;
			end
		end else if (idx == 4'(clc_pkg::FILT_DEPTH)) begin
			// terminator byte 0x00 with last, so an empty list still answers
			o_byte.valid = 1'b1;
			o_byte.last  = 1'b1;
			if (i_ready) begin
				next_busy = 1'b0;
			end
		end else if (!sel_used) begin
			next_idx = idx + 4'h1;
		end else begin
			o_byte.valid = 1'b1;
			o_byte.data  = i_entry[8*bsel +: 8];
			if (i_ready) begin
				next_bsel = bsel + 3'h1;
				if (bsel == 3'h7) begin
					next_idx = idx + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			idx  <= '0;
			bsel <= '0;
			busy <= 1'b0;
		end else begin
			idx  <= next_idx;
			bsel <= next_bsel;
			busy <= next_busy;
		end
	end
endmodule

// ### clc_host.sv
`timescale 1ns/1ps
// ==========================================
// host model: sends bytes and sinks the reply, optionally stalling
module clc_host (
	input  wire logic               i_clk,
	input  wire logic               i_rx_ready,
	input  wire clc_pkg::clc_byte_s i_tx,
	output logic                    o_valid,
	output logic [7:0]              o_data,
	output logic                    o_tx_ready
);
	logic       slow = 1'b0;
	logic       tog  = 1'b0;
	logic [8:0] q[$];
	initial begin
		o_valid = 1'b0;
		o_data = 8'h00;
		o_tx_ready = 1'b1;
	end
	// a slow sink takes every other cycle to expose stall handling
	always @(posedge i_clk) begin
		tog <= ~tog;
		o_tx_ready <= ~slow | tog;
		if (i_tx.valid && o_tx_ready)
			q.push_back({i_tx.last, i_tx.data});
	end
	// byte held until taken; caller sits just after an edge
	task automatic send(input logic [7:0] b);
		o_valid <= 1'b1;
		o_data <= b;
		do @(posedge i_clk); while (i_rx_ready !== 1'b1);
	endtask
	// released line shows the inverse so stale data never looks valid
	task automatic idle();
		o_valid <= 1'b0;
		o_data <= ~o_data;
	endtask
endmodule

// ### can_link_config_commands_tb.sv
`timescale 1ns/1ps
module can_link_config_commands_tb;
	logic                        i_clk     = 1'b0;
	logic                        i_rst     = 1'b1;
	logic                        cfg_enter = 1'b0;
	logic                        filt_we   = 1'b0;
	logic [clc_pkg::FILT_AW-1:0] filt_idx  = '0;
	logic                        filt_used = 1'b0;
	clc_pkg::clc_filt_s          filt      = '0;
	logic                        rx_valid, rx_ready, tx_ready, echo_en, cfg_mode;
	logic [7:0]                  rx_data, rate_idx;
	clc_pkg::clc_byte_s          tx;
	int                          err_count = 0;
	int                          n_checks  = 0;
	int                          cyc       = 0;
	clc_cmd uut (.i_clk(i_clk), .i_rst(i_rst), .i_cfg_enter(cfg_enter), .i_rx_valid(rx_valid),
		.i_rx_data(rx_data), .o_rx_ready(rx_ready), .i_filt_we(filt_we), .i_filt_idx(filt_idx),
		.i_filt_used(filt_used), .i_filt(filt), .i_tx_ready(tx_ready), .o_tx(tx),
		.o_rate_idx(rate_idx), .o_echo_en(echo_en), .o_cfg_mode(cfg_mode));
	clc_host host (.i_clk(i_clk), .i_rx_ready(rx_ready), .i_tx(tx), .o_valid(rx_valid),
		.o_data(rx_data), .o_tx_ready(tx_ready));
	// ==========================================
	// clock and hang guard
	initial forever #10 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			conclude();
		end
	end
	task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// opcode with optional parameter, then settle two cycles
	task automatic cmd(input logic [7:0] op, input logic [7:0] p, input bit two);
		host.send(op);
		if (two)
			host.send(p);
		host.idle();
		repeat (2) @(posedge i_clk);
	endtask
	task automatic wait_q(input int n);
		for (int i = 0; i < 300 && host.q.size() < n; i++) @(posedge i_clk);
		chk("reply count", 9'(host.q.size()), 9'(n));
	endtask
	// ==========================================
	// scenarios
	task automatic t_rate();
		chk("rate rst", {1'b0, rate_idx}, 9'h005);
		chk("ready rst", {8'h00, rx_ready}, 9'h001);
		cmd(8'h05, 8'h03, 1'b1);
		chk("rate cfg off", {1'b0, rate_idx}, 9'h005);
		cfg_enter <= 1'b1;
		@(posedge i_clk);
		cfg_enter <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk("cfg on", {8'h00, cfg_mode}, 9'h001);
		for (int i = 1; i <= 8; i++) begin
			cmd(8'h05, 8'(i), 1'b1);
			chk("rate", {1'b0, rate_idx}, 9'(i));
		end
		cmd(8'h05, 8'h00, 1'b1);
		chk("rate low", {1'b0, rate_idx}, 9'h008);
		cmd(8'h05, 8'h09, 1'b1);
		chk("rate high", {1'b0, rate_idx}, 9'h008);
	endtask
	task automatic t_echo();
		cmd(8'h06, 8'h01, 1'b1);
		chk("echo on", {8'h00, echo_en}, 9'h001);
		cmd(8'h06, 8'h02, 1'b1);
		chk("echo bad", {8'h00, echo_en}, 9'h001);
		cmd(8'h06, 8'h00, 1'b1);
		chk("echo off", {8'h00, echo_en}, 9'h000);
	endtask
	// replies go to a stalling sink
	task automatic t_replies();
		logic [8:0] e[9] = '{9'h044, 9'h033, 9'h022, 9'h011, 9'h088, 9'h077, 9'h066, 9'h055, 9'h100};
		host.slow <= 1'b1;
		cmd(8'h0b, 8'h00, 1'b0);
		wait_q(1);
		chk("rate reply", host.q[0], 9'h108);
		host.q.delete();
		filt_we <= 1'b1;
		filt_idx <= 3'h2;
		filt_used <= 1'b1;
		filt <= '{id: 32'h11223344, mask: 32'h55667788};
		@(posedge i_clk);
		filt_we <= 1'b0;
		cmd(8'h09, 8'h00, 1'b0);
		wait_q(9);
		for (int i = 0; i < 9; i++) chk("filt byte", host.q[i], e[i]);
		host.q.delete();
		// removing the only entry must leave just the terminator
		filt_we <= 1'b1;
		filt_used <= 1'b0;
		@(posedge i_clk);
		filt_we <= 1'b0;
		cmd(8'h09, 8'h00, 1'b0);
		wait_q(1);
		chk("empty list", host.q[0], 9'h100);
		host.q.delete();
		host.slow <= 1'b0;
	endtask
	task automatic t_exit();
		cmd(8'hc1, 8'h00, 1'b0);
		chk("cfg off", {8'h00, cfg_mode}, 9'h000);
		cmd(8'h05, 8'h02, 1'b1);
		chk("rate locked", {1'b0, rate_idx}, 9'h008);
		cmd(8'h0b, 8'h00, 1'b0);
		repeat (4) @(posedge i_clk);
		chk("no reply", 9'(host.q.size()), 9'h000);
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		t_rate();
		t_echo();
		t_replies();
		t_exit();
		conclude();
	end
endmodule
